// File: design/fsc_cfg.svh
// fan speed controller serial port: addresses, reset values, timing
// assumes a 10 MHz core clock and a host-made 100 kHz serial clock
`ifndef FSC_CFG_SVH
`define FSC_CFG_SVH
// ==========================================
// link framing
`define FSC_ADDR 7'h1b
`define FSC_RD 1'b1
`define FSC_WR 1'b0
`define FSC_ACK 1'b0
`define FSC_NACK 1'b1
`define FSC_BYTE_BITS 4'h8
// ==========================================
// command values selecting registers
`define FSC_CMD_SPD1 8'h00
`define FSC_CMD_SPD2 8'h01
`define FSC_CMD_THR1 8'h02
`define FSC_CMD_THR2 8'h03
`define FSC_CMD_CTRL 8'h04
`define FSC_CMD_STAT 8'h05
`define FSC_CMD_DUTY 8'h06
`define FSC_CMD_MAKER 8'h07
`define FSC_CMD_VER 8'h08
// ==========================================
// reset values and field positions
`define FSC_THR_RST 8'h0a
`define FSC_CTRL_RST 8'h0a
`define FSC_DUTY_RST 8'h02
`define FSC_SPD_RST 9'h000
`define FSC_CTRL_RES 6
`define FSC_STAT_OVF1 3
`define FSC_STAT_OVF2 4
`define FSC_SPD_MAX9 9'h1ff
`define FSC_SPD_MAX8 9'h0ff
`define FSC_MEAS_W 12
// ==========================================
// timing
`define FSC_CLK_NS 100
`define FSC_SCL_QTR_NS 2500
`define FSC_QTR_CYC ((`FSC_SCL_QTR_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`endif

// File: design/fsc_pkg.sv
// types shared by both ends of the fan controller serial port
// assumes fsc_cfg.svh is not needed here
package fsc_pkg;
  // ==========================================
  // device end
  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_RECV, D_ACK, D_SEND, D_HACK, D_MORE, D_SKIP
  } fsc_dstate_t;
  typedef struct packed {
    fsc_dstate_t st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic rw;
    logic have_cmd;
    logic [7:0] cmd;
    logic sda_oe_n;
    logic [7:0] thr1;
    logic [7:0] thr2;
    logic [7:0] ctrl;
    logic [7:0] duty;
    logic [8:0] spd1;
    logic [8:0] spd2;
    logic ovf1;
    logic ovf2;
  } fsc_dev_t;
  // ==========================================
  // host end
  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_RECV} fsc_op_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RX, H_STOP} fsc_hstate_t;
  typedef struct packed {
    fsc_hstate_t st;
    logic [7:0] b;
  } fsc_act_t;
  typedef struct packed {
    fsc_hstate_t st;
    fsc_op_t op;
    logic [2:0] step;
    logic [1:0] q;
    logic [7:0] cnt;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [7:0] wdata;
    logic scl;
    logic sda_oe_n;
    logic [7:0] rdata;
    logic err;
    logic done;
  } fsc_host_t;
  // ==========================================
  // synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } fsc_sync_t;
endpackage

// File: design/fsc_if.sv
// two-wire link between host and device, open-drain data line
// assumes a pull-up: the line is high unless someone drives it low
`timescale 1ns/1ps
interface fsc_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;
  // wired-and of both drivers
  assign sda = ~((~host_sda_oe_n & ~host_sda_o) |
                 (~dev_sda_oe_n & ~dev_sda_o));
  modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host(output scl, output host_sda_o, output host_sda_oe_n,
               input sda);
endinterface

// File: design/fsc_sync.sv
// two-flop synchroniser with edge detect behind it
// assumes d comes from outside the clk domain and idles high
`timescale 1ns/1ps
module fsc_sync
  import fsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic d,
  output logic q,
  output logic rise,
  output logic fall
);
  fsc_sync_t r;
  fsc_sync_t next_r;

  // ==========================================
  // shift chain, third stage only for edges
  always_comb begin
    next_r = '{s1: d, s2: r.s1, s3: r.s2};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign q = r.s2;
  assign rise = r.s2 & ~r.s3;
  assign fall = ~r.s2 & r.s3;
endmodule // fsc_sync

// File: design/fsc_device.sv
// fan controller device end: serial slave and its nine registers
// assumes host keeps the link protocol; speed measurements arrive
// from same-clock logic in 25 rpm steps with a valid strobe
`timescale 1ns/1ps
`include "fsc_cfg.svh"
module fsc_device
  import fsc_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter logic VARIANT = 1'b0 // arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  fsc_if.dev bus,
  input wire logic [`FSC_MEAS_W-1:0] fan1_speed_meas,
  input wire logic fan1_meas_valid,
  input wire logic [`FSC_MEAS_W-1:0] fan2_speed_meas,
  input wire logic fan2_meas_valid,
  output logic [7:0] fan1_fault_threshold,
  output logic [7:0] fan2_fault_threshold,
  output logic [7:0] control_settings,
  output logic [7:0] fan_drive_ratio,
  output logic fan1_reading_overflow,
  output logic fan2_reading_overflow
);
  localparam fsc_dev_t RST = '{
    st: D_IDLE, bits: 4'h0, sh: 8'h00, rw: `FSC_WR, have_cmd: 1'b0,
    cmd: `FSC_CMD_SPD1, sda_oe_n: 1'b1,
    thr1: `FSC_THR_RST, thr2: `FSC_THR_RST,
    ctrl: `FSC_CTRL_RST, duty: `FSC_DUTY_RST,
    spd1: `FSC_SPD_RST, spd2: `FSC_SPD_RST,
    ovf1: 1'b0, ovf2: 1'b0
  };

  fsc_dev_t r;
  fsc_dev_t next_r;
  logic scl_h;
  logic scl_rise;
  logic scl_fall;
  logic sda_h;
  logic sda_rise;
  logic sda_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] rd;

  // ==========================================
  // pin synchronisers
  fsc_sync u_scl (
    .clk(clk), .reset_n(reset_n), .ce(ce), .d(bus.scl),
    .q(scl_h), .rise(scl_rise), .fall(scl_fall)
  );
  fsc_sync u_sda (
    .clk(clk), .reset_n(reset_n), .ce(ce), .d(bus.sda),
    .q(sda_h), .rise(sda_rise), .fall(sda_fall)
  );

  // both lines pass the same delay, so edges stay aligned
  assign start_seen = sda_fall & scl_h;
  assign stop_seen = sda_rise & scl_h;

  // ==========================================
  // helpers
  // reading in chosen step, capped at the register range
  function automatic logic [8:0] fsc_reading(
    input logic [`FSC_MEAS_W-1:0] m, input logic res);
    logic [`FSC_MEAS_W-1:0] v;
    logic [`FSC_MEAS_W-1:0] cap;
    v = res ? m : {1'b0, m[`FSC_MEAS_W-1:1]};
    cap = {3'h0, res ? `FSC_SPD_MAX9 : `FSC_SPD_MAX8};
    fsc_reading = (v > cap) ? cap[8:0] : v[8:0];
  endfunction

  // over 12775 rpm
  function automatic logic fsc_over(input logic [`FSC_MEAS_W-1:0] m);
    fsc_over = m > {3'h0, `FSC_SPD_MAX9};
  endfunction

  // register read mux; speed readings give their low eight bits
  function automatic logic [7:0] fsc_rdata(
    input fsc_dev_t s, input logic [7:0] c);
    logic [7:0] st;
    st = 8'h00;
    st[`FSC_STAT_OVF1] = s.ovf1;
    st[`FSC_STAT_OVF2] = s.ovf2;
    case (c)
      `FSC_CMD_SPD1: fsc_rdata = s.spd1[7:0];
      `FSC_CMD_SPD2: fsc_rdata = s.spd2[7:0];
      `FSC_CMD_THR1: fsc_rdata = s.thr1;
      `FSC_CMD_THR2: fsc_rdata = s.thr2;
      `FSC_CMD_CTRL: fsc_rdata = s.ctrl;
      `FSC_CMD_STAT: fsc_rdata = st;
      `FSC_CMD_DUTY: fsc_rdata = s.duty;
      `FSC_CMD_MAKER: fsc_rdata = MAKER_CODE;
      `FSC_CMD_VER: fsc_rdata = {7'h00, VARIANT};
      default: fsc_rdata = 8'h00;
    endcase
  endfunction

  assign rd = fsc_rdata(r, r.cmd);

  // ==========================================
  // next state
  always_comb begin
    next_r = r;
    // fan measurements update the readings
    if (fan1_meas_valid) begin
      next_r.spd1 = fsc_reading(fan1_speed_meas, r.ctrl[`FSC_CTRL_RES]);
      next_r.ovf1 = fsc_over(fan1_speed_meas);
    end
    if (fan2_meas_valid) begin
      next_r.spd2 = fsc_reading(fan2_speed_meas, r.ctrl[`FSC_CTRL_RES]);
      next_r.ovf2 = fsc_over(fan2_speed_meas);
    end
    if (start_seen) begin
      // plain or repeated start: expect an address
      next_r.st = D_ADDR;
      next_r.bits = 4'h0;
      next_r.have_cmd = 1'b0;
      next_r.sda_oe_n = 1'b1;
    end else if (stop_seen) begin
      next_r.st = D_IDLE;
      next_r.sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      // bits are taken while the clock is high
      unique case (r.st)
        D_ADDR, D_RECV: begin
          next_r.sh = {r.sh[6:0], sda_h};
          next_r.bits = r.bits + 4'h1;
        end
        D_SEND: next_r.bits = r.bits + 4'h1;
        D_HACK: next_r.st = (sda_h == `FSC_NACK) ? D_SKIP : D_MORE;
        D_IDLE, D_ACK, D_MORE, D_SKIP: ;
      endcase
    end else if (scl_fall) begin
      // the data line is only moved while the clock is low
      unique case (r.st)
        D_ADDR: begin
          if (r.bits == `FSC_BYTE_BITS) begin
            if (r.sh[7:1] == `FSC_ADDR) begin
              next_r.rw = r.sh[0];
              next_r.sda_oe_n = `FSC_ACK;
              next_r.st = D_ACK;
            end else begin
              next_r.st = D_SKIP;
            end
          end
        end
        D_RECV: begin
          if (r.bits == `FSC_BYTE_BITS) begin
            next_r.sda_oe_n = `FSC_ACK;
            next_r.st = D_ACK;
            if (!r.have_cmd) begin
              next_r.cmd = r.sh;
              next_r.have_cmd = 1'b1;
            end else begin
              case (r.cmd)
                `FSC_CMD_THR1: next_r.thr1 = r.sh;
                `FSC_CMD_THR2: next_r.thr2 = r.sh;
                `FSC_CMD_CTRL: next_r.ctrl = r.sh;
                `FSC_CMD_DUTY: next_r.duty = r.sh;
                default: ;
              endcase
            end
          end
        end
        D_ACK, D_MORE: begin
          next_r.bits = 4'h0;
          if (r.rw == `FSC_RD) begin
            // read byte or receive byte: send selected register
            next_r.sda_oe_n = rd[7];
            next_r.sh = {rd[6:0], 1'b0};
            next_r.st = D_SEND;
          end else begin
            next_r.sda_oe_n = 1'b1;
            next_r.st = D_RECV;
          end
        end
        D_SEND: begin
          if (r.bits == `FSC_BYTE_BITS) begin
            next_r.sda_oe_n = 1'b1;
            next_r.st = D_HACK;
          end else begin
            next_r.sda_oe_n = r.sh[7];
            next_r.sh = {r.sh[6:0], 1'b0};
          end
        end
        D_IDLE, D_HACK, D_SKIP: ;
      endcase
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= RST;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ==========================================
  // outputs
  assign bus.dev_sda_o = 1'b0; // open drain: only ever pulls low
  assign bus.dev_sda_oe_n = r.sda_oe_n;
  assign fan1_fault_threshold = r.thr1;
  assign fan2_fault_threshold = r.thr2;
  assign control_settings = r.ctrl;
  assign fan_drive_ratio = r.duty;
  assign fan1_reading_overflow = r.ovf1;
  assign fan2_reading_overflow = r.ovf2;
endmodule // fsc_device

// File: design/fsc_host.sv
// fan controller host end: runs write, read and receive byte
// assumes one device answering; makes the serial clock by division
`timescale 1ns/1ps
`include "fsc_cfg.svh"
module fsc_host
  import fsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  fsc_if.host bus,
  input wire logic req,
  input wire fsc_op_t op,
  input wire logic [7:0] cmd,
  input wire logic [7:0] wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic nack_err
);
  localparam logic [7:0] QLAST = 8'(`FSC_QTR_CYC - 1);

  fsc_host_t r;
  fsc_host_t next_r;
  fsc_act_t act;
  logic sda_h;
  logic tick;

  fsc_sync u_sda (
    .clk(clk), .reset_n(reset_n), .ce(ce), .d(bus.sda),
    .q(sda_h), .rise(), .fall()
  );

  // ==========================================
  // transfer scripts, one step per phase
  function automatic fsc_act_t fsc_step(
    input fsc_op_t o, input logic [2:0] s,
    input logic [7:0] c, input logic [7:0] w);
    fsc_act_t a;
    logic [7:0] aw;
    logic [7:0] ar;
    aw = {`FSC_ADDR, `FSC_WR};
    ar = {`FSC_ADDR, `FSC_RD};
    a = '{st: H_STOP, b: 8'h00};
    unique case (o)
      OP_WRITE: begin
        case (s)
          3'h0: a = '{st: H_START, b: 8'h00};
          3'h1: a = '{st: H_TX, b: aw};
          3'h2: a = '{st: H_TX, b: c};
          3'h3: a = '{st: H_TX, b: w};
          default: a = '{st: H_STOP, b: 8'h00};
        endcase
      end
      OP_READ: begin
        case (s)
          3'h0, 3'h3: a = '{st: H_START, b: 8'h00};
          3'h1: a = '{st: H_TX, b: aw};
          3'h2: a = '{st: H_TX, b: c};
          3'h4: a = '{st: H_TX, b: ar};
          3'h5: a = '{st: H_RX, b: 8'h00};
          default: a = '{st: H_STOP, b: 8'h00};
        endcase
      end
      OP_RECV: begin
        case (s)
          3'h0: a = '{st: H_START, b: 8'h00};
          3'h1: a = '{st: H_TX, b: ar};
          3'h2: a = '{st: H_RX, b: 8'h00};
          default: a = '{st: H_STOP, b: 8'h00};
        endcase
      end
      default: ;
    endcase
    fsc_step = a;
  endfunction

  assign act = fsc_step(r.op, r.step + 3'h1, r.cmd, r.wdata);
  assign tick = r.cnt == QLAST;

  // ==========================================
  // next state: four quarters per bit or condition
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (r.st == H_IDLE) begin
      if (req) begin
        next_r = '{st: H_START, op: op, step: 3'h0, q: 2'h0, cnt: 8'h00,
                   bits: 4'h0, sh: 8'h00, cmd: cmd, wdata: wdata,
                   scl: r.scl, sda_oe_n: 1'b1, rdata: r.rdata,
                   err: 1'b0, done: 1'b0};
      end
    end else if (!tick) begin
      next_r.cnt = r.cnt + 8'h01;
    end else begin
      next_r.cnt = 8'h00;
      next_r.q = r.q + 2'h1;
      unique case (r.q)
        2'h0: next_r.scl = 1'b1;
        2'h1: begin
          // mid clock-high: start, stop, or sample
          if (r.st == H_START) next_r.sda_oe_n = 1'b0;
          if (r.st == H_STOP) next_r.sda_oe_n = 1'b1;
          if (r.st == H_TX && r.bits == `FSC_BYTE_BITS &&
              sda_h == `FSC_NACK) begin
            next_r.err = 1'b1;
          end
          if (r.st == H_RX && r.bits != `FSC_BYTE_BITS) begin
            next_r.sh = {r.sh[6:0], sda_h};
          end
        end
        2'h2: if (r.st != H_STOP) next_r.scl = 1'b0;
        2'h3: begin
          if (r.st == H_STOP) begin
            next_r.st = H_IDLE;
            next_r.done = 1'b1;
          end else if ((r.st == H_TX || r.st == H_RX) &&
                       r.bits != `FSC_BYTE_BITS) begin
            // next bit; ninth slot is the acknowledge
            next_r.bits = r.bits + 4'h1;
            next_r.sh = (r.st == H_TX) ? {r.sh[6:0], 1'b0} : r.sh;
            if (r.bits == `FSC_BYTE_BITS - 4'h1) begin
              next_r.sda_oe_n = 1'b1;
              if (r.st == H_RX) next_r.rdata = r.sh;
            end else if (r.st == H_TX) begin
              next_r.sda_oe_n = r.sh[6];
            end
          end else begin
            // enter the next phase, or stop after a refusal
            next_r.step = r.step + 3'h1;
            next_r.bits = 4'h0;
            next_r.st = r.err ? H_STOP : act.st;
            next_r.sh = act.b;
            unique case (r.err ? H_STOP : act.st)
              H_TX: next_r.sda_oe_n = act.b[7];
              H_STOP: next_r.sda_oe_n = 1'b0;
              H_IDLE, H_START, H_RX: next_r.sda_oe_n = 1'b1;
            endcase
          end
        end
      endcase
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{st: H_IDLE, op: OP_WRITE, step: 3'h0, q: 2'h0, cnt: 8'h00,
             bits: 4'h0, sh: 8'h00, cmd: 8'h00, wdata: 8'h00,
             scl: 1'b1, sda_oe_n: 1'b1, rdata: 8'h00, err: 1'b0,
             done: 1'b0};
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ==========================================
  // outputs
  assign bus.scl = r.scl;
  assign bus.host_sda_o = 1'b0; // open drain
  assign bus.host_sda_oe_n = r.sda_oe_n;
  assign busy = r.st != H_IDLE;
  assign done = r.done;
  assign rdata = r.rdata;
  assign nack_err = r.err;
endmodule // fsc_host

// File: verification/fsc_link_props.sv
// checker for the serial link between host end and device end
// assumes one clock domain; sees the interface signals as plain inputs
`timescale 1ns/1ps
module fsc_link_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n
);
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  // ==========================================
  // helper counters
  // consecutive high and low samples of the serial clock, saturating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt <= 8'hff;
      lo_cnt <= 8'h00;
    end else begin
      hi_cnt <= !scl ? 8'h00 : ((hi_cnt == 8'hff) ? hi_cnt : hi_cnt + 8'h01);
      lo_cnt <= scl ? 8'h00 : ((lo_cnt == 8'hff) ? lo_cnt : lo_cnt + 8'h01);
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_dev_steady;
    scl && $past(scl) |-> $stable(dev_sda_oe_n);
  endproperty
  a_dev_steady: assert property (p_dev_steady)
    else $error("device data moved while clock high");
  property p_dev_edge;
    !$stable(dev_sda_oe_n) |-> !scl && (lo_cnt inside {[8'h01:8'h08]});
  endproperty
  a_dev_edge: assert property (p_dev_edge)
    else $error("device data moved late in clock low");
  property p_scl_high;
    $fell(scl) |-> (hi_cnt inside {[8'h2d:8'h37]}) || (hi_cnt > 8'h64);
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("serial clock high time wrong");
  property p_scl_low;
    $rose(scl) |-> lo_cnt inside {[8'h2d:8'h37]};
  endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("serial clock low time wrong");
  property p_start;
    $fell(sda) && scl && $past(scl) |-> ##[20:30] !scl;
  endproperty
  a_start: assert property (p_start)
    else $error("start not followed by clock low");
  property p_stop;
    $rose(sda) && scl && $past(scl) |-> (scl && sda) [*8];
  endproperty
  a_stop: assert property (p_stop)
    else $error("bus not idle after stop");
  property p_ack_hold;
    $rose(scl) && !dev_sda_oe_n |-> (!sda) [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("data not held low through clock high");
  // both may pull low while the clock is low; never in the high phase
  property p_no_clash;
    scl && !dev_sda_oe_n |-> host_sda_oe_n;
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("host drives while device drives");
endmodule // fsc_link_props

// File: verification/fan_ctrl_smbus_register_port_test.sv
// testbench: host end and device end joined, plus a hand-driven link
// assumes 10 MHz clock, serial link quarter of 25 cycles on the joined link
`timescale 1ns/1ps
`include "fsc_cfg.svh"
module fan_ctrl_smbus_register_port_test
  import fsc_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
  localparam logic VARIANT = 1'b1; // arbitrary value
  logic clk, reset_n, ce, req, busy, done, nack_err, vld, ovf1, ovf2, a;
  fsc_op_t op;
  logic [7:0] cmd, wdata, rdata, thr1, thr2, ctrl, duty, thr1_b, d;
  logic [11:0] m1, m2;
  int miscompares, total_checks, cycles;
  fsc_if bus_a();
  fsc_if bus_b();
  // ==========================================
  // design ends and checker
  fsc_host fsc_host_i(.clk(clk), .reset_n(reset_n), .ce(ce),
    .bus(bus_a.host), .req(req), .op(op), .cmd(cmd), .wdata(wdata),
    .busy(busy), .done(done), .rdata(rdata), .nack_err(nack_err));
  fsc_device #(.MAKER_CODE(MAKER), .VARIANT(VARIANT)) fsc_device_i(
    .clk(clk), .reset_n(reset_n), .ce(ce), .bus(bus_a.dev),
    .fan1_speed_meas(m1), .fan1_meas_valid(vld), .fan2_speed_meas(m2),
    .fan2_meas_valid(vld), .fan1_fault_threshold(thr1),
    .fan2_fault_threshold(thr2), .control_settings(ctrl),
    .fan_drive_ratio(duty), .fan1_reading_overflow(ovf1),
    .fan2_reading_overflow(ovf2));
  fsc_device fsc_device_i2(.clk(clk), .reset_n(reset_n), .ce(ce),
    .bus(bus_b.dev), .fan1_speed_meas(m1), .fan1_meas_valid(vld),
    .fan2_speed_meas(m2), .fan2_meas_valid(vld),
    .fan1_fault_threshold(thr1_b), .fan2_fault_threshold(),
    .control_settings(), .fan_drive_ratio(), .fan1_reading_overflow(),
    .fan2_reading_overflow());
  fsc_link_props fsc_link_props_i(.clk(clk), .reset_n(reset_n),
    .scl(bus_a.scl), .sda(bus_a.sda), .host_sda_oe_n(bus_a.host_sda_oe_n),
    .dev_sda_oe_n(bus_a.dev_sda_oe_n));
  // ==========================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 90000) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end
  // ==========================================
  // shared tasks
  task end_sim();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one host operation, waits for done under a bound
  task run(input fsc_op_t o, input logic [7:0] c, input logic [7:0] w);
    int n;
    @(negedge clk);
    op = o;
    cmd = c;
    wdata = w;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    chk({7'h00, busy}, 8'h01);
    n = 0;
    while (done !== 1'b1 && n < 8000) begin
      @(negedge clk);
      n = n + 1;
    end
    chk({7'h00, done}, 8'h01);
    chk({7'h00, busy}, 8'h00);
    chk({7'h00, nack_err}, 8'h00);
  endtask
  task rd(input logic [7:0] c, input logic [7:0] exp);
    run(OP_READ, c, 8'h00);
    chk(rdata, exp);
  endtask
  task meas(input logic [11:0] x, input logic [11:0] y);
    @(negedge clk);
    m1 = x;
    m2 = y;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // hand-driven link bits, 800 ns per clock, clock still between frames
  task bb_bit(input logic b, output logic r);
    repeat (2) @(negedge clk);
    bus_b.host_sda_oe_n = b;
    repeat (2) @(negedge clk);
    bus_b.scl = 1'b1;
    repeat (2) @(negedge clk);
    r = bus_b.sda;
    repeat (2) @(negedge clk);
    bus_b.scl = 1'b0;
  endtask
  task bb_edge(input logic first, input logic last);
    repeat (2) @(negedge clk);
    bus_b.host_sda_oe_n = first;
    repeat (2) @(negedge clk);
    bus_b.scl = 1'b1;
    repeat (2) @(negedge clk);
    bus_b.host_sda_oe_n = last;
    repeat (2) @(negedge clk);
    bus_b.scl = last;
  endtask
  task bb_byte(input logic [7:0] x, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bb_bit(x[i], r);
    bb_bit(1'b1, ack);
  endtask
  // ==========================================
  // scenarios
  task t_reset();
    chk(thr1, `FSC_THR_RST);
    chk(thr2, `FSC_THR_RST);
    chk(ctrl, `FSC_CTRL_RST);
    chk(duty, `FSC_DUTY_RST);
    chk({6'h00, ovf2, ovf1}, 8'h00);
    $display("t_reset finished");
  endtask
  task t_write();
    run(OP_WRITE, `FSC_CMD_THR1, 8'h5c);
    run(OP_WRITE, `FSC_CMD_THR2, 8'ha3);
    run(OP_WRITE, `FSC_CMD_DUTY, 8'h81);
    chk(thr1, 8'h5c);
    chk(thr2, 8'ha3);
    chk(duty, 8'h81);
    $display("t_write finished");
  endtask
  task t_read();
    rd(`FSC_CMD_CTRL, `FSC_CTRL_RST);
    rd(`FSC_CMD_MAKER, MAKER);
    rd(`FSC_CMD_VER, {7'h00, VARIANT});
    $display("t_read finished");
  endtask
  task t_recv();
    run(OP_RECV, `FSC_CMD_CTRL, 8'h00);
    chk(rdata, {7'h00, VARIANT});
    run(OP_WRITE, `FSC_CMD_THR2, 8'h3e);
    run(OP_RECV, `FSC_CMD_CTRL, 8'h00);
    chk(rdata, 8'h3e);
    $display("t_recv finished");
  endtask
  task t_ro();
    run(OP_WRITE, `FSC_CMD_MAKER, 8'hff);
    run(OP_WRITE, 8'h09, 8'h55);
    chk(thr1, 8'h5c);
    chk(thr2, 8'h3e);
    chk(ctrl, `FSC_CTRL_RST);
    chk(duty, 8'h81);
    rd(`FSC_CMD_MAKER, MAKER);
    $display("t_ro finished");
  endtask
  task t_speed();
    meas(12'h064, 12'h300);
    rd(`FSC_CMD_SPD1, 8'h32);
    rd(`FSC_CMD_SPD2, 8'hff);
    chk({6'h00, ovf2, ovf1}, 8'h02);
    run(OP_WRITE, `FSC_CMD_CTRL, 8'h4a);
    meas(12'h1f4, 12'h000);
    rd(`FSC_CMD_SPD1, 8'hf4);
    meas(12'h200, 12'h000);
    rd(`FSC_CMD_STAT, 8'h08);
    // clock enable low: a strobe must not reach the flags
    ce = 1'b0;
    meas(12'h000, 12'h300);
    chk({6'h00, ovf2, ovf1}, 8'h01);
    ce = 1'b1;
    $display("t_speed finished");
  endtask
  task t_addr();
    bb_edge(1'b1, 1'b0);
    bb_byte(8'h34, a);
    chk({7'h00, a}, 8'h01);
    bb_byte(`FSC_CMD_THR1, a);
    chk({7'h00, a}, 8'h01);
    bb_edge(1'b0, 1'b1);
    chk(thr1_b, `FSC_THR_RST);
    bb_edge(1'b1, 1'b0);
    bb_byte({`FSC_ADDR, `FSC_WR}, a);
    chk({7'h00, a}, 8'h00);
    bb_byte(`FSC_CMD_THR1, a);
    bb_byte(8'h96, a);
    chk({7'h00, a}, 8'h00);
    bb_edge(1'b0, 1'b1);
    chk(thr1_b, 8'h96);
    bb_edge(1'b1, 1'b0);
    bb_byte({`FSC_ADDR, `FSC_RD}, a);
    chk({7'h00, a}, 8'h00);
    for (int i = 7; i >= 0; i--) bb_bit(1'b1, d[i]);
    bb_bit(1'b1, a);
    chk(d, 8'h96);
    chk({7'h00, a}, 8'h01);
    bb_edge(1'b0, 1'b1);
    $display("t_addr finished");
  endtask
  // ==========================================
  // main sequence
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    req = 1'b0;
    op = OP_WRITE;
    cmd = 8'h00;
    wdata = 8'h00;
    m1 = 12'h000;
    m2 = 12'h000;
    vld = 1'b0;
    bus_b.scl = 1'b1;
    bus_b.host_sda_o = 1'b0;
    bus_b.host_sda_oe_n = 1'b1;
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_write();
    t_read();
    t_recv();
    t_ro();
    t_speed();
    t_addr();
    end_sim();
  end
endmodule // fan_ctrl_smbus_register_port_test
